// >>> pkg/umf_consts.vh
/*
  Constants of the multi-drop filtering serial port: register offsets, field positions,
  reset values and character size codes. Assumes inclusion by the design and the bench.
*/
`ifndef UMF_CONSTS_VH
`define UMF_CONSTS_VH

`define UMF_ADDR_W          3
`define UMF_OFF_DATA        3'h0
`define UMF_OFF_CSA         3'h1
`define UMF_OFF_CSB         3'h2
`define UMF_OFF_CSC         3'h3
`define UMF_OFF_BAUD        3'h4

`define UMF_CSA_RXC         7
`define UMF_CSA_TXC         6
`define UMF_CSA_UDRE        5
`define UMF_CSA_FE          4
`define UMF_CSA_DOR         3
`define UMF_CSA_FILT        0

`define UMF_CSB_RXEN        4
`define UMF_CSB_TXEN        3
`define UMF_CSB_SZ2         2
`define UMF_CSB_RX9         1
`define UMF_CSB_TX9         0

`define UMF_CSC_STOP2       3
`define UMF_CSC_SZ1         2
`define UMF_CSC_SZ0         1

`define UMF_CSC_RESET       8'h06
`define UMF_BAUD_RESET      8'h00
`define UMF_SIZE_NINE       3'h7

`define UMF_OVERSAMPLE      16
`define UMF_VOTE_A          4'h7
`define UMF_VOTE_B          4'h8
`define UMF_VOTE_C          4'h9

`endif

// >>> test/uart_multidrop_filter_data_port_tb_top.sv
/* Bench of the serial port: bus master tasks, far node frames, queue model.
   Assumes the constants header is on the include path. */
`timescale 1ns/1ps
`include "umf_consts.vh"
module uart_multidrop_filter_data_port_tb_top;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00;
  logic       regWrite = 1'b0;
  logic       regRead = 1'b0;
  logic [7:0] regRdata;
  logic       serialInPin;
  logic       serialOutPin;
  logic       serialOutEn;
  int         nFail = 0;
  int         checkCount = 0;
  logic [8:0] expQ[$];
  always #12.5 clk = ~clk;
  umf_serial_port #(.OVERSAMPLE(16)) DUT (.clk, .reset, .regAddr, .regWdata, .regWrite,
    .regRead, .regRdata, .serialInPin, .serialOutPin, .serialOutEn);
  umf_far_node far (.clk, .lineOut(serialInPin));
  task automatic stopTest();
    $display("checks %0d, mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [9:0] e, input logic [9:0] got);
    checkCount++;
    if (got !== e) begin
      nFail++;
      $display("unexpected %s: expected %h, seen %h", what, e, got);
    end
  endtask
  // Strobe drops at the next edge, so the following task starts one cycle later
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic expReg(input string what, input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 cmp(what, {2'b00, e}, {2'b00, regRdata});
  endtask
  task automatic drain(input logic [7:0] filt, input int n);
    logic [8:0] e;
    while (expQ.size() > 0) begin
      e = expQ.pop_front();
      expReg("rx flag", `UMF_OFF_CSA, 8'hA0 | filt);
      if (n == 9) expReg("rx ninth", `UMF_OFF_CSB, {6'h07, e[8], 1'b0});
      expReg("rx data", `UMF_OFF_DATA, e[7:0]);
    end
    expReg("rx empty", `UMF_OFF_CSA, 8'h20 | filt);
  endtask
  // Samples mid-bit from the start edge; returns at the middle of the stop bit
  task automatic expLine(input int n, input logic [8:0] d);
    logic [9:0] got = 10'h000;
    int k = 0;
    while (serialOutPin !== 1'b0 && k < 4000) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k == 4000) begin
      nFail++;
      stopTest();
    end
    repeat (24) @(posedge clk);
    #1;
    for (int i = 0; i <= n; i++) begin
      got[i] = serialOutPin;
      if (i < n) begin
        repeat (16) @(posedge clk);
        #1;
      end
    end
    cmp("tx frame", (10'h001 << n) | ({1'b0, d} & ~(10'h3FF << n)), got);
  endtask
  initial begin
    logic [8:0] d;
    void'($urandom(73));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    expReg("reset A", `UMF_OFF_CSA, 8'h20);
    expReg("unmapped", 3'h6, 8'h00);
    wr(`UMF_OFF_CSA, 8'h01);
    expReg("filter bit", `UMF_OFF_CSA, 8'h21);
    $display("test registers done");
    wr(`UMF_OFF_CSB, 8'h1C);
    for (int i = 0; i < 7; i++) begin
      d = 9'($urandom);
      if (i < 3) d[8] = i[0];
      far.send(9, d, 1'b0);
      if (d[8] || i > 2) expQ.push_back(d);
      if (i == 2) wr(`UMF_OFF_CSA, 8'h00);
      if (i != 5) drain(i < 2 ? 8'h01 : 8'h00, 9);
    end
    for (int j = 0; j < 3; j++) begin
      d = 9'($urandom);
      far.send(9, d, 1'b0);
      if (j < 2) expQ.push_back(d);
    end
    expReg("overrun", `UMF_OFF_CSA, 8'hA8);
    d = expQ.pop_front();
    expReg("first kept", `UMF_OFF_DATA, d[7:0]);
    drain(8'h00, 9);
    $display("test nine-bit filter done");
    wr(`UMF_OFF_CSA, 8'h01);
    wr(`UMF_OFF_CSB, 8'h18);
    for (int n = 5; n < 9; n++) begin
      wr(`UMF_OFF_CSC, 8'(n - 5) << 1);
      for (int t = 0; t < 2; t++) begin
        d = 9'($urandom);
        far.send(n, d, t[0]);
        if (t == 1) expQ.push_back(d & (9'h1FF >> (9 - n)));
      end
      drain(8'h01, n);
    end
    $display("test short frames done");
    wr(`UMF_OFF_CSC, `UMF_CSC_RESET);
    wr(`UMF_OFF_CSB, 8'h1D);
    d = 9'($urandom);
    wr(`UMF_OFF_DATA, d[7:0]);
    wr(`UMF_OFF_DATA, ~d[7:0]);
    wr(`UMF_OFF_DATA, 8'h55);
    expLine(9, {1'b1, d[7:0]});
    expLine(9, {1'b1, ~d[7:0]});
    repeat (100) @(posedge clk);
    expReg("tx done", `UMF_OFF_CSA, 8'h61);
    wr(`UMF_OFF_CSA, 8'h41);
    expReg("tx clear", `UMF_OFF_CSA, 8'h21);
    wr(`UMF_OFF_CSB, 8'h19);
    wr(`UMF_OFF_CSC, 8'h00);
    wr(`UMF_OFF_DATA, 8'hFF);
    expLine(5, 9'h01F);
    wr(`UMF_OFF_CSB, 8'h10);
    repeat (40) @(posedge clk);
    $display("test transmit done");
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    expReg("reset again", `UMF_OFF_CSA, 8'h20);
    $display("test reset done");
    stopTest();
  end
endmodule // uart_multidrop_filter_data_port_tb_top

// >>> test/umf_far_node.sv
/* Far node on the shared line: sends frames into the port.
   Assumes the port's BAUD is zero, so a bit lasts 16 clocks. */
`timescale 1ns/1ps
module umf_far_node (
  input  logic clk,
  output logic lineOut
);
  initial lineOut = 1'b1;
  // Type rides the ninth bit, else the first stop; second stop always high
  task automatic send(input int n, input logic [8:0] d, input logic typ);
    for (int i = -1; i < n + 2; i++) begin
      @(posedge clk);
      lineOut <= i < 0 ? 1'b0 : i < n ? d[i] : i > n || n == 9 || typ;
      repeat (15) @(posedge clk);
    end
  endtask
endmodule // umf_far_node

// >>> test/umf_port_sva.sv
/* Assertions on the port's pins and register reads.
   Assumes BAUD stays zero, so a bit lasts 16 clocks. */
`timescale 1ns/1ps
module umf_port_sva (
  input logic       clk,
  input logic       reset,
  input logic [2:0] regAddr,
  input logic [7:0] regWdata,
  input logic       regWrite,
  input logic       regRead,
  input logic [7:0] regRdata,
  input logic       serialInPin,
  input logic       serialOutPin,
  input logic       serialOutEn
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  rdata_idle_a:
    assert property (!$past(regRead) |-> regRdata == 8'h00) else $error("stray rdata");
  unmapped_read_a:
    assert property (regRead && regAddr > 3'h4 |=> regRdata == 8'h00)
      else $error("unmapped rdata");
  filter_kept_a:
    assert property (regRead && regAddr == 3'h1 && $past(regWrite, 2) && !$past(regWrite)
      && $past(regAddr, 2) == 3'h1 |=> regRdata[0] == $past(regWdata[0], 3))
      else $error("filter bit lost");
  idle_high_a:
    assert property (!serialOutEn |-> serialOutPin) else $error("line low while off");
  frame_enabled_a:
    assert property ($fell(serialOutPin) |-> serialOutEn[*8]) else $error("enable lost");
  start_length_a:
    assert property ($fell(serialOutPin) |-> (!serialOutPin)[*8] ##1 (!serialOutPin)[*7])
      else $error("short start bit");
  enable_cause_a:
    assert property ($rose(serialOutEn) |-> $past(regWrite) && $past(regAddr) == 3'h2)
      else $error("enable without write");
  enable_drop_a:
    assert property ($fell(serialOutEn) |-> serialOutPin && $past(serialOutPin))
      else $error("enable dropped in frame");
endmodule // umf_port_sva

bind umf_serial_port umf_port_sva chk (.clk, .reset, .regAddr, .regWdata, .regWrite,
  .regRead, .regRdata, .serialInPin, .serialOutPin, .serialOutEn);

// >>> verilog/umf_serial_port.v
/*
  Serial transceiver core with multi-drop address filtering and a shared data
  location: transmit holding buffer on write, two-entry receive FIFO on read.
  Assumes one 40 MHz clock, a synchronous active-high reset and a CPU-side
  register port with read data valid in the cycle after the read strobe.
*/
// Notes on behaviour
// - With filtering on, frames without address indication are dropped.
// - For 5 to 8 data bits, first stop bit is the frame type.
// - For nine data bits, the ninth data bit is the frame type.
// - Frame type one means address frame, zero means data frame.
// - Transmitter ignores the filter bit entirely.
// - Address frame under filtering is stored and flags receive complete normally.
// - One data address: write fills transmit buffer, read returns receive buffer.
// - Unused upper bits ignored on transmit and returned zero on receive.
// - Data writes while the buffer-empty flag is clear are ignored.
// - Buffered data moves to empty shift register when enabled, then shifts out.
// - Receive buffer is a two-entry FIFO advanced by every data read while it holds an entry.
// - Filter bit is bit 0 of status register A, read-write, resets zero.
`timescale 1ns/1ps
`include "umf_consts.vh"

module umf_serial_port #(
  parameter OVERSAMPLE = `UMF_OVERSAMPLE
) (
  input  wire                   clk,
  input  wire                   reset,
  input  wire [`UMF_ADDR_W-1:0] regAddr,
  input  wire [7:0]             regWdata,
  input  wire                   regWrite,
  input  wire                   regRead,
  output reg  [7:0]             regRdata,
  input  wire                   serialInPin,
  output reg                    serialOutPin,
  output wire                   serialOutEn
);

  // Control registers
  reg        addrFilterMode_r;
  reg        txCompleteFlag_r;
  reg        rxEnable_r;
  reg        txEnable_r;
  reg        txNinthBit_r;
  reg [7:0]  ctrlC_r;
  reg [7:0]  baudDiv_r;
  reg        ctrlCsb2_r;

  // Last sample of a bit; 4-bit counters limit OVERSAMPLE to 16
  localparam integer PHASE_LAST_I = OVERSAMPLE - 1;
  localparam [3:0]   PHASE_LAST   = PHASE_LAST_I[3:0];

  wire [2:0] charSizeCode = {ctrlCsb2_r, ctrlC_r[`UMF_CSC_SZ1], ctrlC_r[`UMF_CSC_SZ0]};
  wire       nineBit      = (charSizeCode == `UMF_SIZE_NINE);
  wire [3:0] dataBits     = nineBit ? 4'h9 : ({1'b0, charSizeCode} + 4'h5);
  // Codes 4..6 are reserved; treat them as eight bits
  wire [3:0] dataBitsEff  = (charSizeCode > 3'h3 && !nineBit) ? 4'h8 : dataBits;
  wire       twoStop      = ctrlC_r[`UMF_CSC_STOP2];

  // Oversampling tick: one enable pulse per sample period
  // Divider zero ticks on every clock, the fastest bit rate
  reg  [7:0] baudCnt_r;
  wire       sampleTick = (baudCnt_r == 8'h00);
  always @(posedge clk) begin
    if (reset)
      baudCnt_r <= 8'h00;
    else if (sampleTick)
      baudCnt_r <= baudDiv_r;
    else
      baudCnt_r <= baudCnt_r - 8'h01;
  end

  // Bit tick for the transmitter: every OVERSAMPLE sample ticks
  reg  [3:0] txSub_r;
  wire       txBitTick = sampleTick && (txSub_r == PHASE_LAST);
  always @(posedge clk) begin
    if (reset)
      txSub_r <= 4'h0;
    else if (txBitTick)
      txSub_r <= 4'h0;
    else if (sampleTick)
      txSub_r <= txSub_r + 4'h1;
  end

  // Input synchroniser
  // Both stages reset to idle, so no false start follows reset
  reg rxSync1_r;
  reg rxSync2_r;
  always @(posedge clk) begin
    if (reset) begin
      rxSync1_r <= 1'b1;
      rxSync2_r <= 1'b1;
    end else begin
      rxSync1_r <= serialInPin;
      rxSync2_r <= rxSync1_r;
    end
  end

  wire dataWr = regWrite && (regAddr == `UMF_OFF_DATA);
  wire dataRd = regRead && (regAddr == `UMF_OFF_DATA);

  // Transmit path
  reg [8:0]  txHold_r;
  reg        txHoldFull_r;
  reg [10:0] txShift_r;
  reg [3:0]  txLeft_r;
  reg        txBusy_r;
  wire       dataRegEmptyFlag = !txHoldFull_r;
  // Mask of the valid data bits for the configured size
  wire [8:0] sizeMask = (9'h1FF >> (4'h9 - dataBitsEff));
  // Held data waits while the transmitter is off
  wire       txLoad   = txHoldFull_r && txEnable_r && !txBusy_r;

  always @(posedge clk) begin
    if (reset) begin
      txHold_r     <= 9'h000;
      txHoldFull_r <= 1'b0;
      txShift_r    <= 11'h7FF;
      txLeft_r     <= 4'h0;
      txBusy_r     <= 1'b0;
      serialOutPin <= 1'b1;
    end else begin
      if (dataWr && dataRegEmptyFlag) begin
        txHold_r     <= {txNinthBit_r, regWdata} & sizeMask;
        txHoldFull_r <= 1'b1;
      end else if (txLoad)
        txHoldFull_r <= 1'b0;
      // Filter bit deliberately plays no part here
      if (txLoad) begin
        txShift_r <= {2'h3, txHold_r};
        txLeft_r  <= dataBitsEff + (twoStop ? 4'h3 : 4'h2);
        txBusy_r  <= 1'b1;
        serialOutPin <= 1'b1;
      end else if (txBusy_r && txBitTick) begin
        if (txLeft_r == 4'h0) begin
          txBusy_r     <= 1'b0;
          serialOutPin <= 1'b1;
        end else begin
          // Start bit goes out first, then LSB-first data, then stop bits
          if (txLeft_r == dataBitsEff + (twoStop ? 4'h3 : 4'h2))
            serialOutPin <= 1'b0;
          else begin
            serialOutPin <= (txLeft_r > (twoStop ? 4'h2 : 4'h1)) ? txShift_r[0] : 1'b1;
            txShift_r    <= {1'b1, txShift_r[10:1]};
          end
          txLeft_r <= txLeft_r - 4'h1;
        end
      end
    end
  end
  // Pin stays driven until a frame under way has fully left
  assign serialOutEn = txEnable_r || txBusy_r;

  // Receive path: sample counter, majority vote, bit assembly
  reg [3:0]  rxPhase_r;
  reg [3:0]  rxBitIdx_r;
  reg        rxActive_r;
  reg [2:0]  rxVotes_r;
  reg [8:0]  rxShift_r;
  reg        rxDone_r;
  reg        rxStopVal_r;
  wire       vote = (rxVotes_r[0] & rxVotes_r[1]) | (rxVotes_r[0] & rxVotes_r[2])
                  | (rxVotes_r[1] & rxVotes_r[2]);

  always @(posedge clk) begin
    if (reset) begin
      rxPhase_r   <= 4'h0;
      rxBitIdx_r  <= 4'h0;
      rxActive_r  <= 1'b0;
      rxVotes_r   <= 3'h0;
      rxShift_r   <= 9'h000;
      rxDone_r    <= 1'b0;
      rxStopVal_r <= 1'b0;
    end else begin
      rxDone_r <= 1'b0;
      if (!rxEnable_r)
        rxActive_r <= 1'b0;
      else if (sampleTick) begin
        if (!rxActive_r) begin
          if (!rxSync2_r) begin
            rxActive_r <= 1'b1;
            rxPhase_r  <= 4'h1;
            rxBitIdx_r <= 4'h0;
          end
        end else begin
          rxPhase_r <= rxPhase_r + 4'h1;
          if (rxPhase_r == `UMF_VOTE_A)
            rxVotes_r[0] <= rxSync2_r;
          if (rxPhase_r == `UMF_VOTE_B)
            rxVotes_r[1] <= rxSync2_r;
          if (rxPhase_r == `UMF_VOTE_C)
            rxVotes_r[2] <= rxSync2_r;
          if (rxPhase_r == (`UMF_VOTE_C + 4'h1)) begin
            if (rxBitIdx_r == 4'h0) begin
              if (vote)
                rxActive_r <= 1'b0;  // Noise spike, not a start bit
            end else if (rxBitIdx_r <= dataBitsEff)
              rxShift_r[rxBitIdx_r - 4'h1] <= vote;
            else begin
              // Frame completes at the first stop bit; ready for next start
              rxStopVal_r <= vote;
              rxDone_r    <= 1'b1;
              rxActive_r  <= 1'b0;
            end
            rxBitIdx_r <= rxBitIdx_r + 4'h1;
          end
          // Phase zero is the first sample of the next bit
          if (rxPhase_r == PHASE_LAST)
            rxPhase_r <= 4'h0;
        end
      end
    end
  end

  // Frame type and filter decision at frame end
  wire [8:0] rxWord    = rxShift_r & sizeMask;
  wire       frameType = nineBit ? rxShift_r[8] : rxStopVal_r;
  wire       isAddress = frameType;
  wire       rxAccept  = rxDone_r && (isAddress || !addrFilterMode_r);

  // Two-entry receive FIFO: word, ninth bit, frame error
  reg [9:0] rxFifo_r [0:1];
  reg [1:0] rxCount_r;
  reg       rxHead_r;
  reg       overrun_r;
  wire      rxPop  = dataRd && (rxCount_r != 2'h0);
  // A full FIFO still takes a frame when a read frees the head that cycle
  wire      rxPush = rxAccept && ((rxCount_r != 2'h2) || rxPop);
  // Free slot: head when empty or full with the head being freed, else the other entry
  wire      headSel = (rxCount_r == 2'h1) ? ~rxHead_r : rxHead_r;

  // Turning the receiver off flushes the FIFO and its flags

  always @(posedge clk) begin
    if (reset || !rxEnable_r) begin
      rxCount_r <= 2'h0;
      rxHead_r  <= 1'b0;
      overrun_r <= 1'b0;
    end else begin
      if (rxPush)
        rxFifo_r[headSel] <= {~rxStopVal_r, rxWord};
      if (rxPop)
        rxHead_r <= ~rxHead_r;
      rxCount_r <= rxCount_r + {1'b0, rxPush} - {1'b0, rxPop};
      // Overrun clears with the read that makes room
      if (rxAccept && rxCount_r == 2'h2 && !rxPop)
        overrun_r <= 1'b1;
      else if (rxPop)
        overrun_r <= 1'b0;
    end
  end

  wire [9:0] rxHeadWord = (rxCount_r != 2'h0) ? rxFifo_r[rxHead_r] : 10'h000;
  wire       rxCompleteFlag = (rxCount_r != 2'h0);

  // Register writes
  // Complete only when no new data waits behind the finished frame
  wire txDoneEvt = txBusy_r && txBitTick && (txLeft_r == 4'h0) && !txHoldFull_r;
  always @(posedge clk) begin
    if (reset) begin
      addrFilterMode_r <= 1'b0;
      txCompleteFlag_r <= 1'b0;
      rxEnable_r       <= 1'b0;
      txEnable_r       <= 1'b0;
      ctrlCsb2_r       <= 1'b0;
      txNinthBit_r     <= 1'b0;
      ctrlC_r          <= `UMF_CSC_RESET;
      baudDiv_r        <= `UMF_BAUD_RESET;
    end else begin
      // Set wins over the write-one clear
      if (txDoneEvt)
        txCompleteFlag_r <= 1'b1;
      else if (regWrite && regAddr == `UMF_OFF_CSA && regWdata[`UMF_CSA_TXC])
        txCompleteFlag_r <= 1'b0;
      if (regWrite) begin
        case (regAddr)
          `UMF_OFF_CSA: begin
            addrFilterMode_r <= regWdata[`UMF_CSA_FILT];
          end
          `UMF_OFF_CSB: begin
            rxEnable_r   <= regWdata[`UMF_CSB_RXEN];
            txEnable_r   <= regWdata[`UMF_CSB_TXEN];
            ctrlCsb2_r   <= regWdata[`UMF_CSB_SZ2];
            txNinthBit_r <= regWdata[`UMF_CSB_TX9];
          end
          `UMF_OFF_CSC: begin
            ctrlC_r <= regWdata;
          end
          `UMF_OFF_BAUD: begin
            baudDiv_r <= regWdata;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Read mux: data valid the cycle after the strobe
  // Any data read while the FIFO holds an entry pops it, even one made only to poll
  reg [7:0] rdNxt;
  always @* begin
    rdNxt = 8'h00;
    case (regAddr)
      `UMF_OFF_DATA: rdNxt = rxHeadWord[7:0];
      `UMF_OFF_CSA: begin
        rdNxt[`UMF_CSA_RXC]  = rxCompleteFlag;
        rdNxt[`UMF_CSA_TXC]  = txCompleteFlag_r;
        rdNxt[`UMF_CSA_UDRE] = dataRegEmptyFlag;
        rdNxt[`UMF_CSA_FE]   = rxHeadWord[9];
        rdNxt[`UMF_CSA_DOR]  = overrun_r;
        rdNxt[`UMF_CSA_FILT] = addrFilterMode_r;
      end
      `UMF_OFF_CSB: begin
        rdNxt[`UMF_CSB_RXEN] = rxEnable_r;
        rdNxt[`UMF_CSB_TXEN] = txEnable_r;
        rdNxt[`UMF_CSB_SZ2]  = ctrlCsb2_r;
        rdNxt[`UMF_CSB_RX9]  = rxHeadWord[8];
        rdNxt[`UMF_CSB_TX9]  = txNinthBit_r;
      end
      `UMF_OFF_CSC:  rdNxt = ctrlC_r;
      `UMF_OFF_BAUD: rdNxt = baudDiv_r;
      default:       rdNxt = 8'h00;
    endcase
  end

  // Zero between reads, so nothing stale stands on the bus
  always @(posedge clk) begin
    if (reset)
      regRdata <= 8'h00;
    else if (regRead)
      regRdata <= rdNxt;
    else
      regRdata <= 8'h00;
  end

endmodule // umf_serial_port
